// ### pkg/drcr_pkg.sv
// drcr_pkg: register map, masks, serial framing and refresh codes of the host.
// assumes one device-side serial control bus and a row request output per device.
package drcr_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // register addresses on the serial control bus
  localparam logic [7:0] REG_SERIAL_ID      = 8'h01;
  localparam logic [7:0] REG_POWER_MGMT     = 8'h03;
  localparam logic [7:0] REG_SERIAL_LOAD    = 8'h04;
  localparam logic [7:0] REG_SCAN_HIGH      = 8'h06;
  localparam logic [7:0] REG_REFRESH_BANK   = 8'h08;
  localparam logic [7:0] REG_REFRESH_TOP    = 8'h09;
  localparam logic [7:0] REG_REFRESH_MIDDLE = 8'h0a;
  localparam logic [7:0] REG_REFRESH_BOTTOM = 8'h0b;
  localparam logic [7:0] REG_IO_SETUP       = 8'h0f;
  localparam logic [7:0] REG_DRIVE_CAL_EVEN = 8'h10;
  localparam logic [7:0] REG_DRIVE_CAL_ODD  = 8'h11;
  localparam logic [7:0] REG_ORIGIN_INFO    = 8'h16;
  localparam logic [7:0] REG_GEOMETRY       = 8'h17;
  localparam logic [7:0] REG_LATENCY_DELAY  = 8'h1f;

  // reserved address ranges
  localparam logic [7:0] RSV_A_LO = 8'h12;
  localparam logic [7:0] RSV_A_HI = 8'h15;
  localparam logic [7:0] RSV_B_LO = 8'h19;
  localparam logic [7:0] RSV_B_HI = 8'h1d;
  localparam logic [7:0] RSV_C_LO = 8'h80;
  localparam logic [7:0] RSV_C_HI = 8'h8f;

  // defined-bit masks; reserved bits outside them are written and read as zero
  localparam logic [7:0] MASK_ALL          = 8'hff;
  localparam logic [7:0] MASK_NONE         = 8'h00;
  localparam logic [7:0] MASK_PM_WRITE     = 8'h01;
  localparam logic [7:0] MASK_PM_READ      = 8'hc0;
  localparam logic [7:0] MASK_SCAN_HIGH    = 8'h0f;
  localparam logic [7:0] MASK_REFRESH_BANK = 8'hc7;
  localparam logic [7:0] MASK_NIBBLE_LOW   = 8'h0f;
  localparam logic [7:0] MASK_IO_SETUP     = 8'h03;
  localparam logic [7:0] MASK_DRIVE_CAL    = 8'h3f;

  // field positions and legal codes
  localparam int         PM_EXIT_BIT       = 0;
  localparam int         PM_STATE_LSB      = 6;
  localparam logic [1:0] PWR_STATE_DOWN    = 2'h0;
  localparam logic [1:0] PWR_STATE_ACTIVE  = 2'h1;
  localparam int         MBR_LSB           = 6;
  localparam logic [1:0] MBR_SINGLE_BANK   = 2'h0;
  localparam logic [1:0] ODF_NOMINAL       = 2'h0;
  localparam logic [3:0] READ_LAT_SIX      = 4'h6;
  localparam logic [3:0] READ_LAT_SEVEN    = 4'h7;
  localparam logic [3:0] READ_LAT_EIGHT    = 4'h8;
  localparam logic [3:0] WRITE_DELAY_THREE = 4'h3;
  localparam logic [3:0] WRITE_DELAY_FOUR  = 4'h4;

  // serial frame: start, command, 00+id, index, gap, data, end
  localparam int         FRAME_BITS     = 32;
  localparam int         DATA_FIRST_BIT = 23;
  localparam int         DATA_LAST_BIT  = 30;
  localparam logic [3:0] FRAME_START    = 4'hc;
  localparam logic [1:0] SCMD_DEV_WRITE = 2'h0;
  localparam logic [1:0] SCMD_BC_WRITE  = 2'h1;
  localparam logic [1:0] SCMD_DEV_READ  = 2'h2;
  localparam int         SCK_HALF_CYCLES = 6;

  typedef enum logic [1:0] {
    RQ_REFRESH_ACTIVATE  = 2'b00,
    RQ_REFRESH_ACT_INCR  = 2'b01,
    RQ_REFRESH_PRECHARGE = 2'b10
  } drcr_rq_cmd_type;

  typedef enum logic [1:0] {
    UOP_IDLE = 2'b00,
    UOP_WAIT = 2'b01
  } drcr_uop_state_type;

  typedef enum logic [2:0] {
    REF_IDLE = 3'b000,
    REF_ACT  = 3'b001,
    REF_RAS  = 3'b010,
    REF_PRE  = 3'b011,
    REF_RP   = 3'b100
  } drcr_ref_state_type;

  typedef enum logic [0:0] {
    SER_IDLE  = 1'b0,
    SER_SHIFT = 1'b1
  } drcr_ser_state_type;

  function automatic logic [7:0] drcr_write_mask(input logic [7:0] addr);
    if (addr == REG_POWER_MGMT) return MASK_PM_WRITE;
    else if (addr == REG_SCAN_HIGH) return MASK_SCAN_HIGH;
    else if (addr == REG_REFRESH_BANK) return MASK_REFRESH_BANK;
    else if (addr == REG_REFRESH_TOP) return MASK_NONE;
    else if (addr == REG_REFRESH_MIDDLE) return MASK_NIBBLE_LOW;
    else if (addr == REG_IO_SETUP) return MASK_IO_SETUP;
    else if (addr == REG_DRIVE_CAL_EVEN || addr == REG_DRIVE_CAL_ODD) return MASK_DRIVE_CAL;
    else return MASK_ALL;
  endfunction : drcr_write_mask

  function automatic logic [7:0] drcr_read_mask(input logic [7:0] addr);
    if (addr == REG_POWER_MGMT) return MASK_PM_READ;
    else if (addr == REG_SERIAL_LOAD) return MASK_NONE;
    else return drcr_write_mask(addr);
  endfunction : drcr_read_mask

endpackage : drcr_pkg

// ### rtl/drcr_host.sv
// drcr_host: controller for the DRAM control registers and single-bank refresh.
// assumes a user-side register port on this clock and one device on the serial bus;
// the row request pins are abstracted to a command code and bank per pulse.
`timescale 1ns/1ps
// Overview of operation
// - power exit written one only, never zero
// - only single-bank refresh code accepted
// - only nominal overdrive code accepted
// - read latency limited to six-eight
// - write delay limited to three-four
// - reserved register indexes refused
// - refresh activate only to closed bank
// - precharge no sooner than row active time
// - precharge time before reusing the bank
// - every row refreshed each refresh period
// - reserved bits written zero, masked on read
// - registers selected by serial index
module drcr_host
  import drcr_pkg::*;
#(
  parameter int ROW_ACTIVE_TIME_NS = 40,
  parameter int PRECHARGE_TIME_NS  = 20,
  parameter int REFRESH_PERIOD_NS  = 32_000_000,
  parameter int ROW_BITS           = 12,
  parameter int BANK_BITS          = 3
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_reset,
  input  wire logic [5:0]           i_sid,
  input  wire logic                 i_req_valid,
  input  wire logic                 i_req_write,
  input  wire logic                 i_req_broadcast,
  input  wire logic [7:0]           i_req_index,
  input  wire logic [7:0]           i_req_wdata,
  output logic                      o_req_ready,
  output logic                      o_rsp_valid,
  output logic                      o_rsp_error,
  output logic [7:0]                o_rsp_rdata,
  output logic [1:0]                o_power_state,
  output logic                      o_device_active,
  input  wire logic                 i_refresh_enable,
  output logic                      o_rq_valid,
  output logic [1:0]                o_rq_cmd,
  output logic [BANK_BITS-1:0]      o_rq_bank,
  output logic [ROW_BITS-1:0]       o_refresh_row,
  output logic                      o_sck,
  output logic                      o_cmd,
  input  wire logic                 i_sdo
);

  // least times round up, the per-row interval is a longest time and rounds down
  localparam int RAS_RAW  = (ROW_ACTIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_RAW   = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_CYCLES = (RAS_RAW < 1) ? 1 : RAS_RAW;
  localparam int RP_CYCLES  = (RP_RAW < 1) ? 1 : RP_RAW;
  localparam int ROW_COUNT  = 1 << ROW_BITS;
  localparam int IVL_RAW    = REFRESH_PERIOD_NS / (CLK_PERIOD_NS * ROW_COUNT);
  localparam int INTERVAL_CYCLES = (IVL_RAW < 1) ? 1 : IVL_RAW;
  localparam logic [BANK_BITS-1:0] LAST_BANK = {BANK_BITS{1'b1}};

  // user register path
  drcr_uop_state_type uop_state;
  logic [7:0] op_index;
  logic [7:0] op_wdata;
  logic       op_write;
  logic       op_broadcast;
  logic       ser_start;
  logic       ser_busy;
  logic       ser_done;
  logic [7:0] ser_rdata;

  wire logic accept = i_req_valid && o_req_ready;

  // index classification
  wire logic in_rsv_a = (i_req_index >= RSV_A_LO) && (i_req_index <= RSV_A_HI);
  wire logic in_rsv_b = (i_req_index >= RSV_B_LO) && (i_req_index <= RSV_B_HI);
  wire logic in_rsv_c = (i_req_index >= RSV_C_LO) && (i_req_index <= RSV_C_HI);
  wire logic index_reserved = in_rsv_a || in_rsv_b || in_rsv_c;
  wire logic index_read_only = (i_req_index == REG_SERIAL_ID)
                            || (i_req_index == REG_ORIGIN_INFO)
                            || (i_req_index == REG_GEOMETRY);

  // value checks on writes that carry reserved codes
  wire logic [1:0] mbr_code = i_req_wdata[MBR_LSB +: 2];
  wire logic [1:0] odf_code = i_req_wdata[1:0];
  wire logic [3:0] lat_code = i_req_wdata[3:0];
  wire logic [3:0] wdl_code = i_req_wdata[7:4];
  wire logic pm_bad   = (i_req_index == REG_POWER_MGMT)
                     && !i_req_wdata[PM_EXIT_BIT];
  wire logic mbr_bad  = (i_req_index == REG_REFRESH_BANK)
                     && (mbr_code != MBR_SINGLE_BANK);
  wire logic odf_bad  = (i_req_index == REG_IO_SETUP) && (odf_code != ODF_NOMINAL);
  wire logic lat_ok   = (lat_code == READ_LAT_SIX) || (lat_code == READ_LAT_SEVEN)
                     || (lat_code == READ_LAT_EIGHT);
  wire logic wdl_ok   = (wdl_code == WRITE_DELAY_THREE) || (wdl_code == WRITE_DELAY_FOUR);
  wire logic lat_bad  = (i_req_index == REG_LATENCY_DELAY) && !lat_ok;
  wire logic wdl_bad  = (i_req_index == REG_LATENCY_DELAY) && !wdl_ok;
  wire logic value_bad = pm_bad || mbr_bad || odf_bad || lat_bad || wdl_bad;
  wire logic refuse = index_reserved || (i_req_write && (index_read_only || value_bad));

  // reserved bits go out as zero, defined fields untouched
  wire logic [7:0] clean_wdata = i_req_wdata & drcr_write_mask(i_req_index);
  wire logic [7:0] read_mask   = drcr_read_mask(op_index);
  // write-only and reserved bits are dropped; geometry and origin pass whole
  wire logic [7:0] clean_rdata = ser_rdata & read_mask;
  wire logic [1:0] scmd_sel = !op_write ? SCMD_DEV_READ
                            : (op_broadcast ? SCMD_BC_WRITE : SCMD_DEV_WRITE);
  wire logic pm_read_done = ser_done && !op_write && (op_index == REG_POWER_MGMT);
  wire logic [1:0] pm_state_field = ser_rdata[PM_STATE_LSB +: 2];

  drcr_uop_state_type next_uop_state;
  assign next_uop_state = (uop_state == UOP_IDLE) ? ((accept && !refuse) ? UOP_WAIT : UOP_IDLE)
                        : (ser_done ? UOP_IDLE : UOP_WAIT);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      uop_state    <= UOP_IDLE;
      o_req_ready  <= 1'b0;
      op_index     <= 8'h00;
      op_wdata     <= 8'h00;
      op_write     <= 1'b0;
      op_broadcast <= 1'b0;
      ser_start    <= 1'b0;
    end else begin
      uop_state   <= next_uop_state;
      o_req_ready <= (next_uop_state == UOP_IDLE);
      ser_start   <= accept && !refuse;
      if (accept) begin
        op_index     <= i_req_index;
        op_wdata     <= clean_wdata;
        op_write     <= i_req_write;
        op_broadcast <= i_req_broadcast && i_req_write;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rsp_valid <= 1'b0;
      o_rsp_error <= 1'b0;
      o_rsp_rdata <= 8'h00;
    end else begin
      o_rsp_valid <= (accept && refuse) || ser_done;
      o_rsp_error <= accept && refuse;
      if (accept && refuse) begin
        o_rsp_rdata <= 8'h00;
      end else if (ser_done) begin
        o_rsp_rdata <= op_write ? 8'h00 : clean_rdata;
      end
    end
  end

  // power state is known only after a read of it
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_power_state   <= PWR_STATE_ACTIVE;
      o_device_active <= 1'b1;
    end else if (pm_read_done) begin
      o_power_state   <= pm_state_field;
      o_device_active <= (pm_state_field == PWR_STATE_ACTIVE);
    end
  end

  drcr_serial #(
    .HALF_CYCLES (SCK_HALF_CYCLES)
  ) u_serial (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_start   (ser_start),
    .i_scmd    (scmd_sel),
    .i_sid     (i_sid),
    .i_index   (op_index),
    .i_wdata   (op_wdata),
    .i_sdo     (i_sdo),
    .o_busy    (ser_busy),
    .o_done    (ser_done),
    .o_rdata   (ser_rdata),
    .o_sck     (o_sck),
    .o_cmd     (o_cmd)
  );

  // refresh sequencer: one row pass walks all banks once per interval
  drcr_ref_state_type ref_state;
  logic [31:0]          ivl_cnt;
  logic [15:0]          wait_cnt;
  logic                 pending;
  logic [BANK_BITS-1:0] bank;

  wire logic ivl_tick  = (ivl_cnt == 32'h0000_0000);
  wire logic take_pass = (ref_state == REF_IDLE) && pending && i_refresh_enable;
  wire logic wait_done = (wait_cnt == 16'h0000);
  wire logic last_bank = (bank == LAST_BANK);
  // set wins: a tick during the take stays pending
  wire logic next_pending = ivl_tick || (pending && !take_pass);
  // only the last bank advances the row, so every bank sees every row
  wire drcr_rq_cmd_type act_cmd = last_bank ? RQ_REFRESH_ACT_INCR
                                            : RQ_REFRESH_ACTIVATE;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ivl_cnt <= 32'(INTERVAL_CYCLES - 1);
      pending <= 1'b0;
    end else begin
      ivl_cnt <= ivl_tick ? 32'(INTERVAL_CYCLES - 1) : ivl_cnt - 32'h0000_0001;
      pending <= next_pending;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ref_state     <= REF_IDLE;
      wait_cnt      <= 16'h0000;
      bank          <= '0;
      o_refresh_row <= '0;
      o_rq_valid    <= 1'b0;
      o_rq_cmd      <= RQ_REFRESH_ACTIVATE;
      o_rq_bank     <= '0;
    end else begin
      o_rq_valid <= 1'b0;
      case (ref_state)
        REF_IDLE: begin
          if (take_pass) begin
            ref_state <= REF_ACT;
          end
        end
        REF_ACT: begin
          // bank is closed here: its previous precharge time has elapsed
          o_rq_valid <= 1'b1;
          o_rq_cmd   <= act_cmd;
          o_rq_bank  <= bank;
          wait_cnt   <= 16'(RAS_CYCLES - 1);
          ref_state  <= REF_RAS;
        end
        REF_RAS: begin
          if (wait_done) begin
            ref_state <= REF_PRE;
          end else begin
            wait_cnt <= wait_cnt - 16'h0001;
          end
        end
        REF_PRE: begin
          o_rq_valid <= 1'b1;
          o_rq_cmd   <= RQ_REFRESH_PRECHARGE;
          o_rq_bank  <= bank;
          wait_cnt   <= 16'(RP_CYCLES - 1);
          ref_state  <= REF_RP;
        end
        REF_RP: begin
          if (!wait_done) begin
            wait_cnt <= wait_cnt - 16'h0001;
          end else if (last_bank) begin
            bank          <= '0;
            o_refresh_row <= o_refresh_row + 1'b1;
            ref_state     <= REF_IDLE;
          end else begin
            bank      <= bank + 1'b1;
            ref_state <= REF_ACT;
          end
        end
        default: ref_state <= REF_IDLE;
      endcase
    end
  end

  // serial load enable goes out in plain writes; the device steers the data

endmodule : drcr_host

// ### rtl/drcr_serial.sv
// drcr_serial: one 32-bit serial control frame, clock made here by a divider.
// assumes the device samples the command pin on the rising serial clock edge.
`timescale 1ns/1ps
module drcr_serial
  import drcr_pkg::*;
#(
  parameter int HALF_CYCLES = SCK_HALF_CYCLES
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic       i_start,
  input  wire logic [1:0] i_scmd,
  input  wire logic [5:0] i_sid,
  input  wire logic [7:0] i_index,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_sdo,
  output logic            o_busy,
  output logic            o_done,
  output logic [7:0]      o_rdata,
  output logic            o_sck,
  output logic            o_cmd
);

  drcr_ser_state_type state;
  logic [FRAME_BITS-1:0] frame;
  logic [4:0]            bit_idx;
  logic [7:0]            half_cnt;
  logic                  sdo_meta;
  logic                  sdo_sync;

  wire logic            is_read   = i_scmd[1];
  wire logic [7:0]      data_slot = is_read ? 8'h00 : i_wdata;
  wire logic [FRAME_BITS-1:0] new_frame =
    {FRAME_START, i_scmd, 2'b00, i_sid, i_index, 1'b0, data_slot, 1'b0};
  wire logic half_end  = (half_cnt == 8'(HALF_CYCLES - 1));
  wire logic fall_now  = (state == SER_SHIFT) && half_end && o_sck;
  wire logic in_data   = (bit_idx >= 5'(DATA_FIRST_BIT)) && (bit_idx <= 5'(DATA_LAST_BIT));
  wire logic last_bit  = (bit_idx == 5'(FRAME_BITS - 1));

  // the returning data pin is asynchronous to this clock
  always_ff @(posedge i_clk_sys) begin
    sdo_meta <= i_sdo;
    sdo_sync <= sdo_meta;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state    <= SER_IDLE;
      frame    <= 32'h0000_0000;
      bit_idx  <= 5'h00;
      half_cnt <= 8'h00;
      o_busy   <= 1'b0;
      o_done   <= 1'b0;
      o_rdata  <= 8'h00;
      o_sck    <= 1'b0;
      o_cmd    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        SER_IDLE: begin
          o_sck <= 1'b0;
          if (i_start) begin
            state    <= SER_SHIFT;
            frame    <= new_frame << 1;
            o_cmd    <= new_frame[FRAME_BITS-1];
            bit_idx  <= 5'h00;
            half_cnt <= 8'h00;
            o_busy   <= 1'b1;
          end
        end
        SER_SHIFT: begin
          half_cnt <= half_end ? 8'h00 : half_cnt + 8'h01;
          if (half_end) begin
            o_sck <= ~o_sck;
          end
          // sampled late in the high phase so the two-flop delay has settled
          if (fall_now) begin
            if (in_data) begin
              o_rdata <= {o_rdata[6:0], sdo_sync};
            end
            if (last_bit) begin
              state  <= SER_IDLE;
              o_busy <= 1'b0;
              o_done <= 1'b1;
              o_cmd  <= 1'b0;
            end else begin
              bit_idx <= bit_idx + 5'h01;
              o_cmd   <= frame[FRAME_BITS-1];
              frame   <= frame << 1;
            end
          end
        end
        default: state <= SER_IDLE;
      endcase
    end
  end

endmodule : drcr_serial

// ### verif/drcr_dev_model.sv
// drcr_dev_model: behavioural device behind the serial control bus and refresh requests.
// assumes the command pin is stable at serial clock rises.
`timescale 1ns/1ps
module drcr_dev_model
  import drcr_pkg::*;
#(
  parameter logic [5:0] OWN_SID = 6'h05,
  parameter logic [7:0] ORIGIN  = 8'h5a, // arbitrary value
  parameter logic [7:0] GEOM    = 8'h50
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic       i_sck,
  input  wire logic       i_cmd,
  input  wire logic       i_enter_pdn,
  input  wire logic       i_rq_valid,
  input  wire logic [1:0] i_rq_cmd,
  input  wire logic [2:0] i_rq_bank,
  output logic            o_sdo,
  output logic            o_viol
);
  logic [7:0]  regs [256];
  logic [31:0] sh;
  logic [5:0]  cnt;
  logic        sck_d, rd_en;
  logic [1:0]  power_state_field;
  logic [7:0]  opened, rd;
  wire  [31:0] fr    = {sh[30:0], i_cmd};
  wire         rise  = i_sck && !sck_d;
  wire         hit22 = fr[14:9] == OWN_SID || fr[17];
  wire         hit31 = fr[23:18] == OWN_SID || fr[26];
  function automatic logic [7:0] rdv(input logic [7:0] a);
    if (a == REG_POWER_MGMT) return {power_state_field, 6'h00};
    if (a == REG_ORIGIN_INFO) return ORIGIN;
    if (a == REG_GEOMETRY) return GEOM;
    return regs[a];
  endfunction : rdv
  always @(posedge i_clk_sys) begin
    sck_d <= i_sck;
    if (i_reset) begin
      cnt <= 6'h00;
      power_state_field <= PWR_STATE_ACTIVE;
      opened <= 8'h00;
      o_viol <= 1'b0;
      o_sdo <= 1'b1;
      foreach (regs[i]) regs[i] <= 8'h00;
      regs[REG_DRIVE_CAL_EVEN] <= 8'h0f;
      regs[REG_DRIVE_CAL_ODD] <= 8'h0f;
      regs[REG_LATENCY_DELAY] <= 8'h36;
    end else begin
      if (i_enter_pdn) power_state_field <= PWR_STATE_DOWN;
      if (rise) begin
        sh <= fr;
        cnt <= ((cnt == 6'h00 && !i_cmd) || cnt == 6'd31) ? 6'h00 : cnt + 1'b1;
        // a released line toggles so a stale bit cannot pass as data
        o_sdo <= (rd_en && cnt >= 6'd23 && cnt <= 6'd30) ? rd[6'd30 - cnt] : !o_sdo;
        if (cnt == 6'd22) begin
          rd <= rdv(fr[8:1]);
          rd_en <= fr[18] && hit22;
        end
        if (cnt == 6'd31 && !fr[27] && hit31) begin
          if (fr[17:10] == REG_POWER_MGMT) begin
            if (fr[1]) power_state_field <= PWR_STATE_ACTIVE;
          end else regs[fr[17:10]] <= fr[8:1];
        end
      end
      if (i_rq_valid && i_rq_cmd == RQ_REFRESH_PRECHARGE) begin
        o_viol <= o_viol | !opened[i_rq_bank];
        opened[i_rq_bank] <= 1'b0;
      end else if (i_rq_valid) begin
        o_viol <= o_viol | opened[i_rq_bank];
        opened[i_rq_bank] <= 1'b1;
      end
      if (i_rq_valid && i_rq_cmd == RQ_REFRESH_ACT_INCR)
        {regs[8'h0a][3:0], regs[8'h0b]} <= {regs[8'h0a][3:0], regs[8'h0b]} + 1'b1;
    end
  end
endmodule : drcr_dev_model

// ### verif/drcr_host_assertions.sv
// drcr_host_assertions: port-level checks on refusals and the refresh sequence.
// assumes one clock domain and the default refresh timing of the host.
`timescale 1ns/1ps
module drcr_host_assertions
  import drcr_pkg::*;
#(
  parameter int ROW_BITS  = 12,
  parameter int BANK_BITS = 3
) (
  input wire logic                 i_clk_sys,
  input wire logic                 i_reset,
  input wire logic                 i_req_valid,
  input wire logic                 i_req_write,
  input wire logic [7:0]           i_req_index,
  input wire logic [7:0]           i_req_wdata,
  input wire logic                 o_req_ready,
  input wire logic                 o_rsp_valid,
  input wire logic                 o_rsp_error,
  input wire logic [1:0]           o_power_state,
  input wire logic                 o_device_active,
  input wire logic                 o_rq_valid,
  input wire logic [1:0]           o_rq_cmd,
  input wire logic [BANK_BITS-1:0] o_rq_bank,
  input wire logic [ROW_BITS-1:0]  o_refresh_row
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire       wr  = i_req_valid && o_req_ready && i_req_write;
  wire [7:0] ix  = i_req_index;
  wire [7:0] wd  = i_req_wdata;
  wire       rsv = (ix >= RSV_A_LO && ix <= RSV_A_HI) || (ix >= RSV_B_LO && ix <= RSV_B_HI)
                   || (ix >= RSV_C_LO && ix <= RSV_C_HI);
  wire       lat = !(wd[3:0] inside {READ_LAT_SIX, READ_LAT_SEVEN, READ_LAT_EIGHT});
  wire       dly = !(wd[7:4] inside {WRITE_DELAY_THREE, WRITE_DELAY_FOUR});
  wire       act = o_rq_valid && o_rq_cmd != RQ_REFRESH_PRECHARGE;
  wire       pre = o_rq_valid && o_rq_cmd == RQ_REFRESH_PRECHARGE;
  sequence refused_s;
    ##1 (o_rsp_valid && o_rsp_error && o_req_ready);
  endsequence
  chk_reserved_refused: assert property (i_req_valid && o_req_ready && rsv |-> refused_s)
    else $error("reserved index not refused");
  chk_mbr_refused: assert property (wr && ix == REG_REFRESH_BANK && wd[7:6] != 2'h0 |-> refused_s)
    else $error("bad refresh mode not refused");
  chk_odf_refused: assert property (wr && ix == REG_IO_SETUP && wd[1:0] != 2'h0 |-> refused_s)
    else $error("bad overdrive not refused");
  chk_delay_refused: assert property (wr && ix == REG_LATENCY_DELAY && (lat || dly) |-> refused_s)
    else $error("bad latency code not refused");
  chk_px_zero_refused: assert property (wr && ix == REG_POWER_MGMT && !wd[0] |-> refused_s)
    else $error("power exit zero not refused");
  chk_rom_write_refused: assert property (wr && (ix == REG_ORIGIN_INFO || ix == REG_GEOMETRY) |-> refused_s)
    else $error("read-only write not refused");
  chk_act_to_pre: assert property (act |=> !o_rq_valid [*4] ##1 (pre && o_rq_bank == $past(o_rq_bank, 5)))
    else $error("precharge spacing wrong");
  chk_pre_to_act: assert property (pre && o_rq_bank != '1 |=> !o_rq_valid [*2] ##1
    (act && o_rq_bank == $past(o_rq_bank, 3) + 1'b1))
    else $error("next bank activate spacing wrong");
  chk_incr_last_bank: assert property (act |-> (o_rq_cmd == RQ_REFRESH_ACT_INCR) == (o_rq_bank == '1))
    else $error("increment not on last bank");
  chk_row_steps_one: assert property (o_refresh_row != $past(o_refresh_row) |-> o_refresh_row == $past(o_refresh_row) + 1'b1)
    else $error("refresh row jumped");
  chk_active_state: assert property (o_device_active == (o_power_state == PWR_STATE_ACTIVE))
    else $error("active flag disagrees with state");
  cover property (o_rsp_valid && o_rsp_error);
  cover property (o_rsp_valid && !o_rsp_error);
  cover property (o_rq_valid && o_rq_cmd == RQ_REFRESH_ACT_INCR);
endmodule : drcr_host_assertions

bind drcr_host drcr_host_assertions #(.ROW_BITS(ROW_BITS), .BANK_BITS(BANK_BITS)) u_chk (
  .i_clk_sys, .i_reset, .i_req_valid, .i_req_write, .i_req_index, .i_req_wdata, .o_req_ready,
  .o_rsp_valid, .o_rsp_error, .o_power_state, .o_device_active, .o_rq_valid, .o_rq_cmd,
  .o_rq_bank, .o_refresh_row);

// ### verif/drcr_host_tb.sv
// drcr_host_tb: register, refusal, power and refresh tests of drcr_host.
// assumes drcr_dev_model answers frames and watches the refresh requests.
`timescale 1ns/1ps
module drcr_host_tb
  import drcr_pkg::*;
;
  localparam logic [7:0] ORIGIN = 8'h5a; // arbitrary value
  localparam logic [7:0] GEOM   = 8'h50;
  logic        clk = 0, rst = 1, rvalid = 0, rwrite = 0, rbc = 0, ref_en = 0, pdn = 0;
  logic [7:0]  ridx = 8'h00, rwd = 8'h00, rdata;
  logic        ready, rsp_v, rsp_e, active, rq_v, sck, cmd, sdo, viol;
  logic [1:0]  pstate, rq_cmd;
  logic [2:0]  rq_bank;
  logic [3:0]  row;
  int          errors = 0, tests_run = 0, n_act = 0, n_inc = 0;
  logic [15:0] rst_tab [11] = '{16'h0340, 16'h0400, 16'h0600, 16'h0800, 16'h0b00, 16'h0f00,
                                16'h100f, 16'h110f, 16'h1f36, {8'h16, ORIGIN}, {8'h17, GEOM}};
  logic [23:0] wr_tab [8] = '{24'h0aff0f, 24'h0ba5a5, 24'h10ff3f, 24'h112a2a, 24'h1f4848,
                              24'h080707, 24'h06ff0f, 24'h0f0000};
  logic [15:0] bad_tab [14] = '{16'h1200, 16'h1500, 16'h1900, 16'h1d00, 16'h8000, 16'h8f00,
                                16'h1600, 16'h1700, 16'h0300, 16'h0840, 16'h0f01, 16'h1f56,
                                16'h1f39, 16'h1f35};
  drcr_host #(.ROW_BITS(4), .REFRESH_PERIOD_NS(20_000)) DUT (
    .i_clk_sys(clk), .i_reset(rst), .i_sid(6'h05), .i_req_valid(rvalid), .i_req_write(rwrite),
    .i_req_broadcast(rbc), .i_req_index(ridx), .i_req_wdata(rwd), .o_req_ready(ready),
    .o_rsp_valid(rsp_v), .o_rsp_error(rsp_e), .o_rsp_rdata(rdata), .o_power_state(pstate),
    .o_device_active(active), .i_refresh_enable(ref_en), .o_rq_valid(rq_v), .o_rq_cmd(rq_cmd),
    .o_rq_bank(rq_bank), .o_refresh_row(row), .o_sck(sck), .o_cmd(cmd), .i_sdo(sdo));
  drcr_dev_model #(.ORIGIN(ORIGIN), .GEOM(GEOM)) u_dev (
    .i_clk_sys(clk), .i_reset(rst), .i_sck(sck), .i_cmd(cmd), .i_enter_pdn(pdn),
    .i_rq_valid(rq_v), .i_rq_cmd(rq_cmd), .i_rq_bank(rq_bank), .o_sdo(sdo), .o_viol(viol));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rq_v && rq_cmd != RQ_REFRESH_PRECHARGE) n_act++;
    if (rq_v && rq_cmd == RQ_REFRESH_ACT_INCR) n_inc++;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic access(input logic wr, bc, input logic [7:0] idx, wd, input logic err,
                        input logic [7:0] exp);
    int n;
    @(negedge clk);
    while (ready !== 1'b1) @(negedge clk);
    rvalid = 1;
    rwrite = wr;
    rbc = bc;
    ridx = idx;
    rwd = wd;
    @(posedge clk);
    @(negedge clk);
    rvalid = 0;
    for (n = 0; rsp_v !== 1'b1 && n < 1000; n++) @(negedge clk);
    check({7'h00, rsp_v}, 8'h01);
    check({7'h00, rsp_e}, {7'h00, err});
    check(rdata, exp);
  endtask : access
  task automatic give_verdict();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    foreach (rst_tab[i]) access(0, 0, rst_tab[i][15:8], 8'h00, 0, rst_tab[i][7:0]);
    foreach (wr_tab[i]) begin
      access(1, 0, wr_tab[i][23:16], wr_tab[i][15:8], 0, 8'h00);
      access(0, 0, wr_tab[i][23:16], 8'h00, 0, wr_tab[i][7:0]);
    end
    foreach (bad_tab[i]) access(i > 5, 0, bad_tab[i][15:8], bad_tab[i][7:0], 1, 8'h00);
    @(negedge clk) pdn = 1;
    @(negedge clk) pdn = 0;
    access(0, 0, REG_POWER_MGMT, 8'h00, 0, 8'h00);
    check({6'h00, pstate}, 8'h00);
    check({7'h00, active}, 8'h00);
    access(1, 1, REG_POWER_MGMT, 8'h01, 0, 8'h00);
    access(0, 0, REG_POWER_MGMT, 8'h00, 0, 8'h40);
    check({7'h00, active}, 8'h01);
    n_act = 0;
    n_inc = 0;
    @(negedge clk) ref_en = 1;
    for (int k = 0; k < 2000 && n_inc < 2; k++) @(negedge clk);
    ref_en = 0;
    // let the last precharge wait end
    repeat (10) @(negedge clk);
    check(8'(n_act), 8'h10);
    check({4'h0, row}, 8'h02);
    check({7'h00, viol}, 8'h00);
    access(0, 0, REG_REFRESH_BOTTOM, 8'h00, 0, 8'ha7);
    access(0, 0, REG_REFRESH_MIDDLE, 8'h00, 0, 8'h0f);
    give_verdict();
  end
  initial begin
    #500_000;
    errors++;
    give_verdict();
  end
endmodule : drcr_host_tb
